// ==== core/fault_log_params.svh ====
// Constants for the fault logbook and classifier.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FAULT_LOG_PARAMS_SVH
`define FAULT_LOG_PARAMS_SVH
`define LOG_DEPTH 5
`define LOG_IDX_W 3
`define CODE_W 8
`define COUNT_W 8
`define HOURS_W 24
`define TEMP_W 10
`define COUNT_MAX 8'hff
`define COUNT_ONE 8'h01
`define IDX_LAST 3'h4
`define IDX_ZERO 3'h0
`define IDX_ONE 3'h1
`endif

// ==== core/fault_log_pkg.sv ====
// Types shared by the fault logbook and its users.
// Assumes fault_log_params.svh is on the include path.
`default_nettype none
`include "fault_log_params.svh"
package fault_log_pkg;
  // Severity of a reported fault.
  typedef enum logic [1:0] {
    CLASS_NONE,
    CLASS_WARNING,
    CLASS_ALARM
  } fault_class_t;

  // Nature of a detected fault, used to class it.
  typedef struct packed {
    logic operator_sequence;
    logic derating;
    logic drive_failure;
    logic safety_failure;
    logic watchdog;
  } fault_kind_t;

  // One logbook entry.
  typedef struct packed {
    logic [`CODE_W-1:0] code;
    logic [`COUNT_W-1:0] count;
    logic [`HOURS_W-1:0] hours;
    logic [`TEMP_W-1:0] temp;
  } log_entry_t;

  // Power stage commands.
  typedef struct packed {
    logic bridge_enable;
    logic main_contactor;
    logic electromagnetic_brake;
    logic reduce_performance;
    logic regen_stop;
  } power_cmd_t;
endpackage : fault_log_pkg
`default_nettype wire

// ==== core/fault_logbook_and_classifier.sv ====
// Fault classifier and five-entry alarm logbook with power stage control.
// Assumes fault_valid is a one-cycle pulse from logic on the same clock;
// the key switch cycle is the reset.
//
// Operation
// - The logbook holds exactly five entries, each able to hold another alarm.
// - With all entries used, a new different alarm drops the oldest entry.
// - Each entry holds the alarm code and a back-to-back repeat count.
// - An alarm equal to the newest entry only increments that entry's count.
// - The hour meter is captured at first occurrence and kept on repeats.
// - The inverter temperature is captured at first occurrence.
// - An alarm disables the bridge, and opens the contactor and applies the brake where the hardware allows.
// - A warning keeps power enabled and derates or stops by regen braking.
// - Operator sequence and derating faults are classed as warnings.
// - Drive failures and safety failures are classed as alarms.
// - Watchdog alarms clear only at key cycle, others on a new request.
`default_nettype none
`include "fault_log_params.svh"
module fault_logbook_and_classifier
  import fault_log_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fault_valid,
  input wire logic [`CODE_W-1:0] fault_code,
  input wire fault_kind_t fault_kind,
  input wire logic [`HOURS_W-1:0] hour_meter,
  input wire logic [`TEMP_W-1:0] inverter_temp,
  input wire logic new_request,
  input wire logic contactor_possible,
  input wire logic brake_possible,
  input wire logic regen_stop_select,
  input wire logic [`LOG_IDX_W-1:0] read_index,
  output logic [`LOG_IDX_W-1:0] log_used,
  output log_entry_t read_entry,
  output power_cmd_t power_cmd,
  output logic alarm_active,
  output logic warning_active
);

  ////////////////////////////////////////////////////////////////////////
  // Classification.
  fault_class_t fclass;
  logic is_alarm;
  logic is_warning;

  // Hard failures win over soft ones so a doubtful report stops the truck.
  always_comb begin
    if (fault_kind.drive_failure || fault_kind.safety_failure ||
        fault_kind.watchdog) begin
      fclass = CLASS_ALARM;
    end else if (fault_kind.operator_sequence || fault_kind.derating) begin
      fclass = CLASS_WARNING;
    end else begin
      fclass = CLASS_NONE;
    end
  end

  assign is_alarm = fault_valid && (fclass == CLASS_ALARM);
  assign is_warning = fault_valid && (fclass == CLASS_WARNING);

  ////////////////////////////////////////////////////////////////////////
  // Latched alarm and warning state.
  logic alarm_reg, alarm_next;
  logic wd_reg, wd_next;
  logic warn_reg, warn_next;

  // The watchdog latch has no clear path: only reset, i.e. key cycle.
  always_comb begin
    alarm_next = alarm_reg;
    wd_next = wd_reg;
    warn_next = warn_reg;
    if (new_request) begin
      alarm_next = 1'b0;
      warn_next = 1'b0;
    end
    if (is_alarm) begin
      alarm_next = 1'b1;
    end
    if (is_alarm && fault_kind.watchdog) begin
      wd_next = 1'b1;
    end
    if (is_warning) begin
      warn_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'b0;
      wd_reg <= 1'b0;
      warn_reg <= 1'b0;
    end else begin
      alarm_reg <= alarm_next;
      wd_reg <= wd_next;
      warn_reg <= warn_next;
    end
  end

  assign alarm_active = alarm_reg || wd_reg;
  assign warning_active = warn_reg && !alarm_active;

  ////////////////////////////////////////////////////////////////////////
  // Power stage commands, registered.
  power_cmd_t cmd_reg, cmd_next;

  // Contactor and brake act only where the hardware still allows it.
  always_comb begin
    cmd_next.bridge_enable = !alarm_active;
    cmd_next.main_contactor = !(alarm_active && contactor_possible);
    cmd_next.electromagnetic_brake = alarm_active && brake_possible;
    cmd_next.reduce_performance = warning_active && !regen_stop_select;
    cmd_next.regen_stop = warning_active && regen_stop_select;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  assign power_cmd = cmd_reg;

  ////////////////////////////////////////////////////////////////////////
  // Logbook: entry 0 is the newest, entry LOG_DEPTH-1 the oldest.
  log_entry_t log_reg [`LOG_DEPTH];
  log_entry_t log_next [`LOG_DEPTH];
  logic [`LOG_IDX_W-1:0] used_reg, used_next;
  logic repeat_hit;
  log_entry_t fresh;

  assign repeat_hit = (used_reg != `IDX_ZERO) &&
                      (log_reg[0].code == fault_code);
  assign fresh = '{code: fault_code, count: `COUNT_ONE,
                   hours: hour_meter, temp: inverter_temp};

  // A new alarm shifts every entry one place older; the last falls off.
  always_comb begin
    used_next = used_reg;
    for (int i = 0; i < `LOG_DEPTH; i++) begin
      log_next[i] = log_reg[i];
    end
    if (is_alarm && repeat_hit) begin
      if (log_reg[0].count != `COUNT_MAX) begin
        log_next[0].count = log_reg[0].count + `COUNT_ONE;
      end
    end else if (is_alarm) begin
      log_next[0] = fresh;
      for (int i = 1; i < `LOG_DEPTH; i++) begin
        log_next[i] = log_reg[i-1];
      end
      if (used_reg != 3'(`LOG_DEPTH)) begin
        used_next = used_reg + `IDX_ONE;
      end
    end
  end

  // Entries are generated so each register has its own reset.
  genvar g;
  generate
    for (g = 0; g < `LOG_DEPTH; g++) begin : g_entry
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          log_reg[g] <= '0;
        end else begin
          log_reg[g] <= log_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      used_reg <= `IDX_ZERO;
    end else begin
      used_reg <= used_next;
    end
  end

  assign log_used = used_reg;

  // Console read port; out-of-range or empty slots read as zero.
  log_entry_t rd_reg, rd_next;
  always_comb begin
    rd_next = '0;
    if (read_index < used_reg) begin
      rd_next = log_reg[read_index];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign read_entry = rd_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_new_alarm;
    is_alarm && !repeat_hit;
  endsequence

  chk_log_depth_cap: assert property (@(posedge clock) disable iff (!rst_n)
    log_used <= `LOG_DEPTH) else $error("log fill beyond depth");

  chk_fifo_shift: assert property (@(posedge clock) disable iff (!rst_n)
    s_new_alarm |=> log_reg[1] == $past(log_reg[0]))
    else $error("entries did not shift on new alarm");

  chk_new_entry: assert property (@(posedge clock) disable iff (!rst_n)
    s_new_alarm |=> log_reg[0].count == `COUNT_ONE &&
      log_reg[0].code == $past(fault_code))
    else $error("new entry code or count wrong");

  chk_repeat_count: assert property (@(posedge clock) disable iff (!rst_n)
    is_alarm && repeat_hit && log_reg[0].count != `COUNT_MAX |=>
      log_reg[0].count == $past(log_reg[0].count) + `COUNT_ONE &&
      log_used == $past(log_used))
    else $error("repeat did not bump count");

  chk_hours_kept: assert property (@(posedge clock) disable iff (!rst_n)
    is_alarm && repeat_hit |=> $stable(log_reg[0].hours) &&
      $stable(log_reg[0].temp))
    else $error("first occurrence data changed");

  chk_temp_capture: assert property (@(posedge clock) disable iff (!rst_n)
    s_new_alarm |=> log_reg[0].temp == $past(inverter_temp) &&
      log_reg[0].hours == $past(hour_meter))
    else $error("capture wrong");

  chk_alarm_power: assert property (@(posedge clock) disable iff (!rst_n)
    is_alarm |=> ##1 !power_cmd.bridge_enable)
    else $error("bridge not opened on alarm");

  chk_warning_power: assert property (@(posedge clock) disable iff (!rst_n)
    is_warning && !alarm_active && !new_request |=> ##1
      power_cmd.bridge_enable)
    else $error("warning opened bridge");

  chk_count_sat: assert property (@(posedge clock) disable iff (!rst_n)
    log_reg[0].count == `COUNT_MAX && is_alarm && repeat_hit |=>
      log_reg[0].count == `COUNT_MAX)
    else $error("count wrapped");

  chk_watchdog_hold: assert property (@(posedge clock) disable iff (!rst_n)
    wd_reg |=> wd_reg)
    else $error("watchdog cleared without key cycle");

endmodule : fault_logbook_and_classifier
`default_nettype wire

// ==== sim/log_console.sv ====
// Service console model that reads logbook slots one at a time.
// Assumes read_entry answers one clock after read_index changes.
`default_nettype none
`include "fault_log_params.svh"
module log_console
  import fault_log_pkg::*;
(
  input wire logic clock,
  output logic [`LOG_IDX_W-1:0] read_index,
  input wire log_entry_t read_entry
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////
  // The idle index points past the log, so a stale answer reads zero.
  initial read_index = 3'h7;
  // Changes move on falling edges, away from the design's sampling.
  task automatic read_slot(input logic [2:0] idx, output log_entry_t e);
    @(negedge clock);
    read_index = idx;
    @(negedge clock);
    e = read_entry;
    read_index = 3'h7;
  endtask : read_slot
endmodule : log_console
`default_nettype wire

// ==== sim/test_fault_logbook_and_classifier.sv ====
// Self-checking bench for the fault classifier and alarm logbook.
// Assumes the design package and header are compiled first.
`default_nettype none
module test_fault_logbook_and_classifier;
  timeunit 1ns;
  timeprecision 1ns;
  import fault_log_pkg::*;
  // One fault and the flags, fill level and power bits it should give.
  typedef struct packed {
    logic [4:0] kind;
    logic [7:0] code;
    logic [7:0] want;
  } row_t;
  row_t rows[10] = '{'{5'h10, 8'h01, 8'h46}, '{5'h08, 8'h02, 8'h46},
    '{5'h00, 8'h03, 8'h46}, '{5'h04, 8'h10, 8'h89}, '{5'h02, 8'h11, 8'h91},
    '{5'h04, 8'h11, 8'h91}, '{5'h02, 8'h12, 8'h99}, '{5'h04, 8'h13, 8'ha1},
    '{5'h04, 8'h14, 8'ha9}, '{5'h04, 8'h15, 8'ha9}};
  logic clock = 0, rst_n = 0, fault_valid = 0, new_request = 0;
  logic contactor_possible = 1, brake_possible = 1, regen_stop_select = 0;
  logic [7:0] fault_code = 8'h00;
  fault_kind_t fault_kind = '0;
  logic [23:0] hour_meter = 24'h000000;
  logic [9:0] inverter_temp = 10'h000;
  logic [2:0] read_index, log_used;
  log_entry_t read_entry, e;
  power_cmd_t power_cmd;
  logic alarm_active, warning_active;
  int bad_count = 0, total_checks = 0;
  ////////////////////////////////////////////////////////////////////
  // Clock at 100 ns period.
  always #50 clock = ~clock;
  fault_logbook_and_classifier i_fault_logbook_and_classifier (
    .clock(clock), .rst_n(rst_n), .fault_valid(fault_valid),
    .fault_code(fault_code), .fault_kind(fault_kind),
    .hour_meter(hour_meter), .inverter_temp(inverter_temp),
    .new_request(new_request), .contactor_possible(contactor_possible),
    .brake_possible(brake_possible), .regen_stop_select(regen_stop_select),
    .read_index(read_index), .log_used(log_used), .read_entry(read_entry),
    .power_cmd(power_cmd), .alarm_active(alarm_active),
    .warning_active(warning_active));
  log_console i_log_console (.clock(clock), .read_index(read_index),
    .read_entry(read_entry));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Power bits lag the fault by two edges, so wait past both.
  task automatic pulse(input logic [4:0] kind, input logic [7:0] code);
    @(negedge clock);
    fault_kind = kind;
    fault_code = code;
    fault_valid = 1;
    @(negedge clock);
    fault_valid = 0;
    fault_code = ~code;
    @(negedge clock);
  endtask : pulse
  task automatic request;
    @(negedge clock);
    new_request = 1;
    @(negedge clock);
    new_request = 0;
    @(negedge clock);
  endtask : request
  ////////////////////////////////////////////////////////////////////
  // A hang would leave the run silent, so a limit ends it as failed.
  initial begin
    #500000;
    bad_count++;
    report_and_stop();
  end
  // Main sequence: table rows first, then the awkward cases.
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1;
    @(negedge clock);
    check({log_used, power_cmd}, {3'h0, 5'h18});
    foreach (rows[i]) begin
      hour_meter = 24'h000100 + 24'(i);
      inverter_temp = 10'h020 + 10'(i);
      pulse(rows[i].kind, rows[i].code);
      check({alarm_active, warning_active, log_used, power_cmd[4:2]},
        rows[i].want);
    end
    i_log_console.read_slot(3'h0, e);
    check(e, {8'h15, 8'h01, 24'h000109, 10'h029});
    i_log_console.read_slot(3'h4, e);
    check(e, {8'h11, 8'h02, 24'h000104, 10'h024});
    i_log_console.read_slot(3'h5, e);
    check(e, 50'h0);
    request();
    check({alarm_active, warning_active, power_cmd}, 7'h18);
    contactor_possible = 0;
    brake_possible = 0;
    pulse(5'h04, 8'h20);
    check(power_cmd[4:2], 3'b010);
    contactor_possible = 1;
    brake_possible = 1;
    request();
    pulse(5'h01, 8'h08);
    request();
    check({alarm_active, power_cmd}, 6'h24);
    rst_n = 0;
    @(negedge clock);
    rst_n = 1;
    @(negedge clock);
    check({alarm_active, log_used, power_cmd}, 9'h018);
    regen_stop_select = 1;
    pulse(5'h08, 8'h05);
    check({warning_active, log_used, power_cmd}, 9'h119);
    regen_stop_select = 0;
    repeat (2) @(negedge clock);
    check(power_cmd, 5'h1a);
    // Back-to-back repeats push the counter to its top value, where it holds.
    fault_kind = 5'h04;
    fault_code = 8'h30;
    fault_valid = 1;
    hour_meter = 24'h000777;
    for (int n = 1; n < 260; n++) begin
      @(negedge clock);
      hour_meter = 24'h000777 + 24'(n);
    end
    @(negedge clock);
    fault_valid = 0;
    i_log_console.read_slot(3'h0, e);
    check(e, {8'h30, 8'hff, 24'h000777, 10'h029});
    report_and_stop();
  end
endmodule : test_fault_logbook_and_classifier
`default_nettype wire
